// file: rtl/fault_latch_pkg.sv
package fault_latch_pkg;
    // ==================================================
    // channel and frame shape
    localparam int NUM_CH = 6;
    localparam int FRAME_BITS = 16;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] FRAME_LEN = 8'h10;
    localparam int PAD_BITS = FRAME_BITS - 2 * NUM_CH;
    localparam int SYNC_W = 3 + 4 * NUM_CH;
    // ==================================================
    // two-bit fault codes
    localparam logic [1:0] CODE_NONE = 2'h0;
    localparam logic [1:0] CODE_OPEN = 2'h1;
    localparam logic [1:0] CODE_GND = 2'h2;
    localparam logic [1:0] CODE_SHORTED = 2'h3;
    // ==================================================
    // fields of the received word
    localparam int MASK_LSB = 0;
    localparam int RETRY_EN_LSB = 6;
    localparam logic [NUM_CH-1:0] MASK_RST = 6'h00;
    localparam logic [NUM_CH-1:0] RETRY_EN_RST = 6'h3f;
    // ==================================================
    // timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int BLANK_TIME_NS = 10000;
    localparam int FILTER_TIME_NS = 5000;
    localparam int RETRY_TIME_MS = 10;
    localparam int TMR_W = 10;
    localparam int RETRY_W = 19;
    localparam logic [TMR_W-1:0] BLANK_CYC =
        TMR_W'((BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] FILTER_CYC =
        TMR_W'((FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int RETRY_CYC = RETRY_TIME_MS * 1000000 / CLK_PERIOD_NS;
endpackage

// file: rtl/fault_latch_readback.sv
`timescale 1ns/1ps
// How it works
// - fault capture sets latch, and fault flag if unmasked
// - filled latch ignores later codes until valid
// - chip select fall snapshots latches, drops flag
// - valid frame end re-arms all latches
// - invalid frame writes no register
// - persisting fault recaptured right after re-arm
// - primary enable H-L-H clears latches, flag
// - frame returns sixteen bits, two per channel
// - running timers hold back latch updates
// - short at timer end: gate low, retry
// - retry expiry re-drives gate, restarts blanking
// - status flag follows unmasked open-load comparison
// - off channel below ground threshold faults
// - filter starts only on new abnormal state
// - unread latch loads live status at end
// - no live fault leaves flag released
// - recapture at frame end reasserts flag
// - codes 00 none, 01 open, 10 ground, 11 short
// - flag needs fault, mask clear, enables, select
// - either enable low stops fault diagnostics; status flag needs only primary enable high
module fault_latch_readback
    import fault_latch_pkg::*;
#(
    parameter logic [RETRY_W-1:0] RETRY_CYCLES = RETRY_W'(RETRY_CYC)
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic spi_clk_i,
    input wire logic chip_sel_n_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    output logic spi_miso_oe_o,
    input wire logic primary_enable_i,
    input wire logic secondary_enable_i,
    input wire logic [NUM_CH-1:0] cmd_on_i,
    input wire logic [NUM_CH-1:0] drain_above_shorted_i,
    input wire logic [NUM_CH-1:0] drain_below_open_i,
    input wire logic [NUM_CH-1:0] drain_below_ground_i,
    output logic [NUM_CH-1:0] gate_drive_o,
    output logic fault_flag_n_o,
    output logic status_flag_n_o
);
    // ==================================================
    // state of the core domain
    typedef struct packed {
        logic [SYNC_W-1:0] s1; // first synchroniser stage
        logic [SYNC_W-1:0] s2; // second synchroniser stage
        logic cs_n_prev; // select level one cycle ago
        logic en_prev; // both enables one cycle ago
        logic [NUM_CH-1:0] cmd_prev; // command one cycle ago
        logic [NUM_CH-1:0][1:0] cmp_prev; // comparison one cycle ago
        logic [NUM_CH-1:0][1:0] live; // live fault status
        logic [NUM_CH-1:0][1:0] latch; // captured fault codes
        logic [NUM_CH-1:0][TMR_W-1:0] blank; // blanking timers
        logic [NUM_CH-1:0][TMR_W-1:0] filt; // filter timers
        logic [NUM_CH-1:0][RETRY_W-1:0] retry; // auto-retry timers
        logic [NUM_CH-1:0] shut; // gate held off by a short
        logic [NUM_CH-1:0] gate; // gate drive
        logic [NUM_CH-1:0] mask; // flag mask bits
        logic [NUM_CH-1:0] retry_en; // auto-retry versus latch-off
        logic flt; // pending fault notification
        logic fault_n; // fault flag pin
        logic stat_n; // status flag pin
        logic miso_oe; // serial output enable
        logic [FRAME_BITS-1:0] snap; // readback word
        logic [CNT_W-1:0] cnt_start; // edge count at frame start
    } core_t;

    // state of the serial clock domain
    typedef struct packed {
        logic [CNT_W-1:0] cnt; // free edge count
        logic [FRAME_BITS-1:0] rx; // received bits
        logic miso; // serial output bit
    } link_t;

    core_t q, d;
    link_t lq = '0; // counts are used only as differences
    link_t ld;

    // synchronised inputs
    logic cs_n_s, en1_s, en2_s, en_both;
    logic [NUM_CH-1:0] cmd_s, asl_s, bol_s, bgs_s;
    logic cs_fall, cs_rise, valid_end;
    logic [NUM_CH-1:0][1:0] cmp; // comparison per channel
    logic [NUM_CH-1:0] tmr_end; // a blanking or filter timer ends
    logic [NUM_CH-1:0] capture; // latch takes a new unmasked fault

    assign {cs_n_s, en1_s, en2_s, cmd_s, asl_s, bol_s, bgs_s} = q.s2;
    assign en_both = en1_s & en2_s;
    assign cs_fall = q.cs_n_prev & ~cs_n_s;
    assign cs_rise = ~q.cs_n_prev & cs_n_s;
    assign valid_end = cs_rise && (CNT_W'(lq.cnt - q.cnt_start) == FRAME_LEN);

    // ==================================================
    // drain comparison against the commanded state
    // fault code encoding
    function automatic logic [1:0] classify(input logic on, input logic asl,
                                            input logic bol, input logic bgs);
        logic [1:0] c;
        c = CODE_NONE;
        if (on) begin
            c = asl ? CODE_SHORTED : CODE_NONE;
        end else if (bgs) begin
            c = CODE_GND;
        end else if (bol) begin
            c = CODE_OPEN;
        end
        return c;
    endfunction

    // ==================================================
    // next state of the core domain
    always_comb begin
        d = q;
        d.s1 = {chip_sel_n_i, primary_enable_i, secondary_enable_i, cmd_on_i,
                drain_above_shorted_i, drain_below_open_i, drain_below_ground_i};
        d.s2 = q.s1;
        d.cs_n_prev = cs_n_s;
        d.en_prev = en_both;
        d.cmd_prev = cmd_s;
        for (int i = 0; i < NUM_CH; i++) begin
            cmp[i] = classify(cmd_s[i], asl_s[i], bol_s[i], bgs_s[i]);
            tmr_end[i] = (q.blank[i] == TMR_W'(1)) || (q.filt[i] == TMR_W'(1));
            capture[i] = 1'b0;
            d.cmp_prev[i] = cmp[i];
            // timers count down to zero
            if (q.blank[i] != '0) begin
                d.blank[i] = q.blank[i] - TMR_W'(1);
            end
            if (q.filt[i] != '0) begin
                d.filt[i] = q.filt[i] - TMR_W'(1);
            end
            if (q.retry[i] != '0) begin
                d.retry[i] = q.retry[i] - RETRY_W'(1);
            end
            if (!en_both) begin
                d.blank[i] = '0;
                d.filt[i] = '0;
                d.retry[i] = '0;
                d.shut[i] = 1'b0;
                d.live[i] = CODE_NONE;
            end else begin
                if (!q.en_prev || cmd_s[i] != q.cmd_prev[i]) begin
                    d.blank[i] = BLANK_CYC;
                    d.filt[i] = '0;
                end else if (cmp[i] != q.cmp_prev[i] && cmp[i] != CODE_NONE
                             && q.blank[i] == '0) begin
                    d.filt[i] = FILTER_CYC;
                end
                if (!cmd_s[i]) begin
                    d.shut[i] = 1'b0;
                end
                // fault codes enter status only at timer end
                if (tmr_end[i]) begin
                    d.live[i] = cmp[i];
                    if (cmp[i] == CODE_SHORTED) begin
                        d.shut[i] = 1'b1;
                        d.retry[i] = RETRY_CYCLES;
                    end
                end else if (cmp[i] == CODE_NONE && q.blank[i] == '0
                             && q.filt[i] == '0) begin
                    // back to good needs no filter
                    d.live[i] = CODE_NONE;
                end
                if (q.retry[i] == RETRY_W'(1) && cmd_s[i] && q.retry_en[i]) begin
                    d.shut[i] = 1'b0;
                    d.blank[i] = BLANK_CYC;
                end
                if (tmr_end[i] && q.latch[i] == CODE_NONE && cmp[i] != CODE_NONE) begin
                    d.latch[i] = cmp[i];
                    capture[i] = ~q.mask[i];
                end
            end
            d.gate[i] = en_both & cmd_s[i] & ~d.shut[i];
        end
        if (|capture) begin
            d.flt = 1'b1;
        end else if (cs_fall) begin
            d.flt = 1'b0;
        end
        if (cs_fall) begin
            d.snap = {{PAD_BITS{1'b0}}, q.latch};
            d.cnt_start = lq.cnt;
        end
        if (valid_end) begin
            // unread data waits for this edge
            d.latch = d.live;
            // writes only on a valid frame
            d.mask = lq.rx[MASK_LSB +: NUM_CH];
            d.retry_en = lq.rx[RETRY_EN_LSB +: NUM_CH];
            // no live fault keeps the flag released
            d.flt = 1'b0;
            for (int i = 0; i < NUM_CH; i++) begin
                // recapture under the new mask raises the flag
                if (d.live[i] != CODE_NONE && !d.mask[i]) begin
                    d.flt = 1'b1;
                end
            end
        end
        if (!en1_s) begin
            d.latch = '0;
            d.flt = 1'b0;
        end
        d.fault_n = ~(d.flt & en_both & cs_n_s);
        d.stat_n = ~(en1_s & |(bol_s & ~q.mask));
        d.miso_oe = ~cs_n_s;
    end

    // ==================================================
    // core registers
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q <= '0;
            q.cs_n_prev <= 1'b1;
            // select idles high, so no false frame edge follows reset
            q.s1 <= '0;
            q.s1[SYNC_W-1] <= 1'b1;
            q.s2[SYNC_W-1] <= 1'b1;
            q.mask <= MASK_RST;
            q.retry_en <= RETRY_EN_RST;
            q.fault_n <= 1'b1;
            q.stat_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ==================================================
    // serial clock domain: shift in, shift out, count edges
    always_comb begin
        ld = lq;
        if (!chip_sel_n_i) begin
            ld.cnt = lq.cnt + CNT_W'(1);
            ld.rx = {lq.rx[FRAME_BITS-2:0], spi_mosi_i};
            ld.miso = q.snap[4'hf - 4'(lq.cnt - q.cnt_start)];
        end
    end

    always_ff @(posedge spi_clk_i) begin
        lq <= ld;
    end

    assign spi_miso_o = lq.miso;
    assign spi_miso_oe_o = q.miso_oe;
    assign gate_drive_o = q.gate;
    assign fault_flag_n_o = q.fault_n;
    assign status_flag_n_o = q.stat_n;

    // ==================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    AST_CAPTURE_FLAG: assert property (
        capture[0] && en_both && cs_n_s && !cs_rise |=> q.flt && !fault_flag_n_o)
        else $error("capture did not raise the fault flag");
    AST_LATCH_HOLD: assert property (
        q.latch[0] != CODE_NONE && en1_s && !valid_end |=> $stable(q.latch[0]))
        else $error("filled latch changed without a valid frame");
    AST_SNAPSHOT: assert property (
        cs_fall |=> q.snap[2*NUM_CH-1:0] == $past(q.latch) ##1 fault_flag_n_o)
        else $error("select fall did not snapshot or release");
    AST_REARM: assert property (
        valid_end && en1_s |=> q.latch == $past(d.live))
        else $error("valid frame did not reload latches");
    AST_BAD_FRAME: assert property (
        cs_rise && !valid_end |=> $stable(q.mask) && $stable(q.retry_en))
        else $error("invalid frame wrote a register");
    AST_ENABLE_CLEAR: assert property (
        !en1_s |=> q.latch == '0 ##1 fault_flag_n_o)
        else $error("primary enable low did not clear");
    AST_FLAG_GATE: assert property (
        !fault_flag_n_o |-> $past(en_both && cs_n_s))
        else $error("fault flag asserted while gated");
    AST_SHORT_OFF: assert property (
        en_both && tmr_end[1] && cmp[1] == CODE_SHORTED
        |=> !gate_drive_o[1] && q.retry[1] == RETRY_CYCLES)
        else $error("short did not shut gate and arm retry");
    AST_RETRY: assert property (
        en_both && q.retry[1] == RETRY_W'(1) && cmd_s[1] && q.retry_en[1]
        && $stable(cmd_s[1]) |=> q.blank[1] == BLANK_CYC)
        else $error("retry expiry did not restart blanking");
    AST_STATUS: assert property (
        !en1_s |=> status_flag_n_o)
        else $error("status flag asserted with enable low");

    COV_CAPTURE: cover property (capture[0] ##[1:20] !fault_flag_n_o);
    COV_VALID: cover property (valid_end);
    COV_BAD: cover property (cs_rise && !valid_end);
    COV_RETRY: cover property (q.retry[1] == RETRY_W'(1) && q.retry_en[1]);
endmodule

// file: verif/spi_host_model.sv
`timescale 1ns/1ps
// ==================================================
// host serial master, clock runs only inside frames
module spi_host_model (
    input wire logic spi_miso_i,
    output logic spi_clk_o,
    output logic chip_sel_n_o,
    output logic spi_mosi_o,
    output logic [15:0] rd_word_o,
    output logic rd_done_o
);
    // idle levels: clock low, select high
    initial begin
        spi_clk_o = 1'b0;
        chip_sel_n_o = 1'b1;
        spi_mosi_o = 1'b0;
        rd_word_o = 16'h0000;
        rd_done_o = 1'b0;
    end

    // one frame with a chosen count of clock edges
    task automatic xfer(input logic [15:0] wr, input int edges);
        logic [15:0] sh;
        sh = 16'h0000;
        #7;
        chip_sel_n_o = 1'b0;
        // setup time after select fall
        #100;
        for (int k = 0; k < edges; k++) begin
            spi_mosi_o = wr[(15-k)%16];
            #32 spi_clk_o = 1'b1;
            #32 spi_clk_o = 1'b0;
            // miso sampled on the falling edge
            sh = {sh[14:0], spi_miso_i};
        end
        #100;
        chip_sel_n_o = 1'b1;
        // released line must not keep its last level
        spi_mosi_o = ~spi_mosi_o;
        rd_word_o = sh;
        rd_done_o = 1'b1;
        #1 rd_done_o = 1'b0;
        // select high gap between frames
        #120;
    endtask
endmodule

// file: verif/fault_latch_readback_tb.sv
`timescale 1ns/1ps
// ==================================================
// self-checking bench for fault capture and readback
module fault_latch_readback_tb;
    import fault_latch_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i, primary_enable_i, secondary_enable_i;
    logic [NUM_CH-1:0] cmd_on_i, drain_above_shorted_i, drain_below_open_i;
    logic [NUM_CH-1:0] drain_below_ground_i, gate_drive_o;
    logic spi_clk, chip_sel_n, spi_mosi, spi_miso, spi_miso_oe, rd_done;
    logic fault_flag_n_o, status_flag_n_o;
    logic [15:0] rd_word;
    logic [15:0] exp_q[$]; // expected readback words
    logic [31:0] lfsr = 32'heda5; // pad bits of written words
    int failures = 0;
    int total_checks = 0;

    // core clock 50 MHz
    always #10 clk_i = ~clk_i;

    fault_latch_readback #(.RETRY_CYCLES(19'h007d0)) i_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .spi_clk_i(spi_clk),
        .chip_sel_n_i(chip_sel_n), .spi_mosi_i(spi_mosi),
        .spi_miso_o(spi_miso), .spi_miso_oe_o(spi_miso_oe),
        .primary_enable_i(primary_enable_i), .secondary_enable_i(secondary_enable_i),
        .cmd_on_i(cmd_on_i), .drain_above_shorted_i(drain_above_shorted_i),
        .drain_below_open_i(drain_below_open_i), .drain_below_ground_i(drain_below_ground_i),
        .gate_drive_o(gate_drive_o), .fault_flag_n_o(fault_flag_n_o),
        .status_flag_n_o(status_flag_n_o));

    spi_host_model i_host (
        .spi_miso_i(spi_miso), .spi_clk_o(spi_clk), .chip_sel_n_o(chip_sel_n),
        .spi_mosi_o(spi_mosi), .rd_word_o(rd_word), .rd_done_o(rd_done));

    // ==================================================
    // reporting
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic give_verdict();
        if (failures == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // monitor: each finished frame takes the oldest note
    always @(posedge rd_done) begin
        if (exp_q.size() == 0) check("readback_queue", 16'h0001, 16'h0000);
        else check("readback", exp_q.pop_front(), rd_word);
        // select sync delay keeps the output enable up at frame end
        check("miso_oe_frame", 16'h0001, {15'h0, spi_miso_oe});
    end

    // ==================================================
    // stimulus helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // note the expected word, then run a frame
    task automatic frame(input logic [15:0] exp, input logic [5:0] mask, input int edges);
        lfsr = lfsr_next(lfsr);
        exp_q.push_back(exp);
        i_host.xfer({lfsr[3:0], 6'h3f, mask}, edges);
    endtask

    // bounded wait: sel 0 fault flag, sel 1 gate of channel 1
    task automatic wait_for(input int sel, input logic v, input int n);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < n && !hit; i++) begin
            @(negedge clk_i);
            hit = (((sel == 0) ? fault_flag_n_o : gate_drive_o[1]) === v);
        end
        total_checks++;
        if (!hit) begin
            failures++;
            $display("[ERR] wait %0d expected %b seen timeout", sel, v);
            give_verdict();
        end
    endtask

    // ==================================================
    // main sequence, inputs change on the falling edge
    initial begin
        rst_n_i = 1'b0;
        primary_enable_i = 1'b0;
        secondary_enable_i = 1'b0;
        cmd_on_i = '0;
        drain_above_shorted_i = '0;
        drain_below_open_i = '0;
        drain_below_ground_i = '0;
        repeat (5) @(negedge clk_i);
        rst_n_i = 1'b1;
        check("fault_flag", 16'h0001, {15'h0, fault_flag_n_o});
        check("gate", 16'h0000, {10'h0, gate_drive_o});
        check("miso_oe_idle", 16'h0000, {15'h0, spi_miso_oe});
        repeat (3) @(negedge clk_i);
        // open load on channel 0 while off
        drain_below_open_i[0] = 1'b1;
        primary_enable_i = 1'b1;
        secondary_enable_i = 1'b1;
        repeat (5) @(negedge clk_i);
        check("status_flag", 16'h0000, {15'h0, status_flag_n_o});
        wait_for(0, 1'b0, 1000);
        frame(16'h0001, 6'h00, 16);
        wait_for(0, 1'b0, 10);
        // channel 0 moves into ground short: latch must hold
        @(negedge clk_i);
        drain_below_ground_i[0] = 1'b1;
        repeat (300) @(negedge clk_i);
        frame(16'h0001, 6'h00, 16);
        frame(16'h0002, 6'h01, 16);
        repeat (5) @(negedge clk_i);
        check("masked_flag", 16'h0001, {15'h0, fault_flag_n_o});
        // short frame must not rewrite the mask
        frame(16'h0001, 6'h00, 15);
        repeat (5) @(negedge clk_i);
        check("mask_kept", 16'h0001, {15'h0, fault_flag_n_o});
        // a cleared mask would let the open load pull the status flag
        check("mask_kept_status", 16'h0001, {15'h0, status_flag_n_o});
        drain_below_open_i[0] = 1'b0;
        drain_below_ground_i[0] = 1'b0;
        repeat (5) @(negedge clk_i);
        check("status_flag", 16'h0001, {15'h0, status_flag_n_o});
        frame(16'h0002, 6'h00, 16);
        repeat (5) @(negedge clk_i);
        check("flag_clear", 16'h0001, {15'h0, fault_flag_n_o});
        frame(16'h0000, 6'h00, 16);
        // shorted load on channel 1 with auto retry
        @(negedge clk_i);
        cmd_on_i[1] = 1'b1;
        drain_above_shorted_i[1] = 1'b1;
        wait_for(1, 1'b1, 10);
        wait_for(1, 1'b0, 1000);
        wait_for(0, 1'b0, 10);
        frame(16'h000c, 6'h00, 16);
        wait_for(1, 1'b1, 2500);
        wait_for(1, 1'b0, 600);
        // primary enable high-low-high clears latches and fault flag
        primary_enable_i = 1'b0;
        repeat (5) @(negedge clk_i);
        check("enable_off_flag", 16'h0001, {15'h0, fault_flag_n_o});
        check("enable_off_gate", 16'h0000, {10'h0, gate_drive_o});
        primary_enable_i = 1'b1;
        frame(16'h0000, 6'h00, 16);
        repeat (20) @(negedge clk_i);
        give_verdict();
    end
endmodule
